/* File: logic/rxwb_pkg.sv */
// constants for the receive descriptor write-back and interrupt block
package rxwb_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ICR = 8'h04;
  localparam logic [7:0] OFF_IMS = 8'h08;
  localparam logic [7:0] OFF_PDT = 8'h0c;
  localparam logic [7:0] OFF_ADT = 8'h10;
  localparam logic [7:0] OFF_SRPD = 8'h14;
  localparam logic [7:0] OFF_ACKD = 8'h18;
  // rings at 0x40 and 0x60, sub offsets inside a ring
  localparam logic [1:0] RING_AREA = 2'h1;
  localparam logic [4:0] RO_BAL = 5'h00;
  localparam logic [4:0] RO_BAH = 5'h04;
  localparam logic [4:0] RO_LEN = 5'h08;
  localparam logic [4:0] RO_HEAD = 5'h0c;
  localparam logic [4:0] RO_TAIL = 5'h10;
  // control fields
  localparam int WTH_LSB = 0;
  localparam int WTH_W = 6;
  localparam int DTYP_LSB = 8;
  localparam int EXST_BIT = 10;
  localparam int MINTH_LSB = 12;
  localparam logic [1:0] DTYP_PSPLIT = 2'h1;
  localparam int FPD_BIT = 31;
  // cause bits
  localparam int C_RXT = 0;
  localparam int C_MINTH = 1;
  localparam int C_OVR = 2;
  localparam int C_SRPD = 3;
  localparam int C_ACK = 4;
  localparam int NCAUSE = 5;
  // descriptor geometry
  localparam int DESC_SHIFT = 4;
  localparam int BASE_IGN = 4;
  localparam logic [16:0] LINE_DESCS = 17'h00004;
  localparam logic [7:0] DD_ONLY = 8'h01;
  // timer granularity
  localparam int TICK_NS = 1024;
  localparam int CLK_NS = 40;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
endpackage

/* File: logic/rxwb_top.sv */
// receive descriptor write-back engine with ring and interrupt moderation
// Overview of operation
// [RL1] used 16-byte descriptors pile up and go out in cache-line chunks
// [RL2] pending count reaching writeback_threshold forces an immediate write-back
// [RL3] using the ring's last descriptors forces write-back to realign at start
// [RL4] timer expiry first flushes all used descriptors, then raises cause
// [RL5] writing packet_delay_timer with top bit set flushes and updates head
// [RL6] null-buffer descriptor stores no data, written back with only done bit
// [RL7] software avoids null padding with packet-split descriptors
// [RL8] two circular rings; head and tail wrap to base after ring size
// [RL9] ring_head names next write-back, advances by count written
// [RL10] head equal to tail means empty; stop storing packets
// [RL11] software writes tail past last valid entry, two per split descriptor
// [RL12] device owns head up to tail; software owns the rest
// [RL13] ring base is 64 bits over two words, low 4 bits ignored
// [RL14] software programs ring_length as a multiple of 128 bytes
// [RL15] shadow head counts completed but unwritten descriptors; 64K descriptors
// [RL16] packet completion reloads packet delay timer; expiry raises timer cause
// [RL17] packet delay timer zero signals each packet at once
// [RL18] absolute timer starts only when idle on completion; never reloaded
// [RL19] any receive interrupt resets both timers until next completion; the ack cause does not reset them
// [RL20] nonzero small threshold: shorter packet sets small and timer causes
// [RL21] ack detection needs split type or extended status; fires after delay
// [RL22] free count hitting fraction sets min cause; full FIFO write sets overrun
// [RL23] causes stay latched until cleared; interrupt only when unmasked
module rxwb_top
  import rxwb_pkg::*;
#(
  parameter int TICK = rxwb_pkg::TICK_CYC
) (
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  input wire logic I_CE,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_DESC_USED,
  input wire logic I_DESC_RING,
  input wire logic I_DESC_NULL,
  input wire logic I_PKT_DONE,
  input wire logic [15:0] I_PKT_LEN,
  input wire logic I_PKT_ACK,
  input wire logic I_FIFO_WR,
  input wire logic I_FIFO_FULL,
  output logic O_STORE_EN,
  output logic [7:0] O_NULL_STATUS,
  output logic [1:0] O_RING_EMPTY,
  output logic O_FIFO_DROP,
  output logic O_WB_REQ,
  output logic O_WB_RING,
  output logic [63:0] O_WB_ADDR,
  output logic [16:0] O_WB_CNT,
  input wire logic I_WB_ACK,
  input wire logic I_WB_DONE,
  output logic O_IRQ
);
  import rxwb_pkg::*;

  typedef enum logic [1:0] {WB_IDLE, WB_REQ, WB_WAIT} rxwb_st_t;

  logic [31:0] ctrl_q, ims_q, pdt_q, adt_q, srpd_q, ackd_q, prdata_q;
  logic [NCAUSE-1:0] icr_q, cause_set;
  logic [31:4] bal_q [2];
  logic [31:0] bah_q [2];
  logic [20:0] len_q [2];
  logic [15:0] tail_q [2], head_q [2], sh_q [2];
  logic [16:0] pend_q [2], ndesc [2], cnt_w [2];
  logic [1:0] want, mt_hit;
  logic wr, rd_setup, hit, ring_sel, ring_acc, wr_icr;
  logic [4:0] sub;
  rxwb_st_t wb_st_q;
  logic wb_ring_q, flush_q, tmr_pend_q, done_ev;
  logic [16:0] wb_cnt_q;
  logic [15:0] pdt_cnt_q, adt_cnt_q, ack_cnt_q;
  logic pdt_act_q, adt_act_q, ack_act_q, tick;
  logic [15:0] tick_q;
  logic small_evt, ovr_evt, ack_en, intr_any, tmr_exp, rxt_flushed;

  // apb decode; zero wait states, unmapped offsets answer with an error
  assign wr = I_PSEL & I_PENABLE & I_PWRITE & I_CE;
  assign rd_setup = I_PSEL & ~I_PENABLE & ~I_PWRITE & I_CE;
  assign ring_acc = (I_PADDR[7:6] == RING_AREA) && (I_PADDR[4:0] <= RO_TAIL)
                    && (I_PADDR[1:0] == 2'h0);
  assign ring_sel = I_PADDR[5];
  assign sub = I_PADDR[4:0];
  assign hit = ring_acc || (I_PADDR <= OFF_ACKD && I_PADDR[1:0] == 2'h0);
  assign wr_icr = wr && I_PADDR == OFF_ICR;
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = I_PSEL & I_PENABLE & ~hit;
  assign O_PRDATA = prdata_q;

  // read data caught in the setup phase so the bus sees a flop
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      prdata_q <= 32'h0;
    end else if (rd_setup) begin
      prdata_q <= 32'h0;
      if (ring_acc) begin
        unique case (sub)
          RO_BAL: prdata_q <= {bal_q[ring_sel], {BASE_IGN{1'b0}}}; // see [RL13]
          RO_BAH: prdata_q <= bah_q[ring_sel];
          RO_LEN: prdata_q <= {11'h0, len_q[ring_sel]};
          RO_HEAD: prdata_q <= {16'h0, head_q[ring_sel]}; // see [RL9]
          RO_TAIL: prdata_q <= {16'h0, tail_q[ring_sel]};
          default: prdata_q <= 32'h0;
        endcase
      end else begin
        unique case (I_PADDR)
          OFF_CTRL: prdata_q <= ctrl_q;
          OFF_ICR: prdata_q <= {27'h0, icr_q};
          OFF_IMS: prdata_q <= ims_q;
          OFF_PDT: prdata_q <= {16'h0, pdt_q[15:0]};
          OFF_ADT: prdata_q <= {16'h0, adt_q[15:0]};
          OFF_SRPD: prdata_q <= srpd_q;
          OFF_ACKD: prdata_q <= ackd_q;
          default: prdata_q <= 32'h0;
        endcase
      end
    end
  end

  // global configuration registers
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ctrl_q <= 32'h0;
      ims_q <= 32'h0;
      pdt_q <= 32'h0;
      adt_q <= 32'h0;
      srpd_q <= 32'h0;
      ackd_q <= 32'h0;
    end else if (wr) begin
      unique case (I_PADDR)
        OFF_CTRL: ctrl_q <= I_PWDATA;
        OFF_IMS: ims_q <= I_PWDATA;
        OFF_PDT: pdt_q <= {16'h0, I_PWDATA[15:0]}; // flush bit is not stored
        OFF_ADT: adt_q <= {16'h0, I_PWDATA[15:0]};
        OFF_SRPD: srpd_q <= {16'h0, I_PWDATA[15:0]};
        OFF_ACKD: ackd_q <= {16'h0, I_PWDATA[15:0]};
        default: ;
      endcase
    end
  end

  // per-ring pointers; shadow head runs ahead of the visible head
  for (genvar r = 0; r < 2; r++) begin : g_ring
    logic used, done_here, to_end_hit, line_hit, wth_hit;
    logic [16:0] sh_inc, sh_nxt, free_after, thr, to_end;
    assign used = I_DESC_USED && I_DESC_RING == 1'(r) && I_CE;
    assign done_here = done_ev && wb_ring_q == 1'(r);
    assign ndesc[r] = {len_q[r][20:DESC_SHIFT]};
    assign sh_inc = {1'b0, sh_q[r]} + 17'h1;
    assign sh_nxt = (sh_inc >= ndesc[r]) ? 17'h0 : sh_inc; // see [RL8]
    assign free_after = ({1'b0, tail_q[r]} >= sh_nxt) ?
                        {1'b0, tail_q[r]} - sh_nxt : {1'b0, tail_q[r]} + ndesc[r] - sh_nxt;
    assign thr = ndesc[r] >> ({1'b0, ctrl_q[MINTH_LSB +: 2]} + 3'h1);
    assign mt_hit[r] = used && free_after == thr; // see [RL22]
    assign to_end = ndesc[r] - {1'b0, head_q[r]};
    assign cnt_w[r] = (pend_q[r] < to_end) ? pend_q[r] : to_end;
    // last ring entries used: write out so the next chunk starts at base
    assign to_end_hit = pend_q[r] >= to_end; // see [RL3]
    assign line_hit = pend_q[r] >= LINE_DESCS - {15'h0, head_q[r][1:0]}; // see [RL1]
    assign wth_hit = ctrl_q[WTH_LSB +: WTH_W] != 6'h0 &&
                     pend_q[r] >= {11'h0, ctrl_q[WTH_LSB +: WTH_W]}; // see [RL2]
    assign want[r] = pend_q[r] != 17'h0 && (flush_q || to_end_hit || line_hit || wth_hit);
    assign O_RING_EMPTY[r] = sh_q[r] == tail_q[r]; // see [RL10]

    // software-owned ring description
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
        bal_q[r] <= 28'h0;
        bah_q[r] <= 32'h0;
        len_q[r] <= 21'h0;
        tail_q[r] <= 16'h0;
      end else if (wr && ring_acc && ring_sel == 1'(r)) begin
        unique case (sub)
          RO_BAL: bal_q[r] <= I_PWDATA[31:BASE_IGN]; // see [RL13]
          RO_BAH: bah_q[r] <= I_PWDATA;
          RO_LEN: len_q[r] <= I_PWDATA[20:0];
          RO_TAIL: tail_q[r] <= I_PWDATA[15:0]; // see [RL11]
          default: ;
        endcase
      end
    end

    // shadow head, pending count and visible head
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
        sh_q[r] <= 16'h0;
        head_q[r] <= 16'h0;
        pend_q[r] <= 17'h0;
      end else begin
        if (used && !O_RING_EMPTY[r]) begin // see [RL12]
          sh_q[r] <= sh_nxt[15:0]; // see [RL15]
        end
        if (done_here) begin
          // advance by exactly the chunk just written, wrapping at size
          head_q[r] <= (({1'b0, head_q[r]} + wb_cnt_q) >= ndesc[r]) ? 16'h0 :
                       16'(head_q[r] + wb_cnt_q[15:0]); // see [RL9]
        end
        pend_q[r] <= pend_q[r] + {16'h0, used && !O_RING_EMPTY[r]}
                     - (done_here ? wb_cnt_q : 17'h0);
      end
    end
  end

  // data is never stored behind a null buffer address
  assign O_STORE_EN = ~I_DESC_NULL; // see [RL6]

  // status byte for a null descriptor: done bit only, other bits written as zero
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_NULL_STATUS <= 8'h0;
    end else if (I_CE && I_DESC_USED && I_DESC_NULL) begin
      O_NULL_STATUS <= DD_ONLY; // see [RL6]
    end
  end

  // write-back engine; ring 0 wins when both rings want the port
  assign done_ev = wb_st_q == WB_WAIT && I_WB_DONE && I_CE;
  assign O_WB_REQ = wb_st_q == WB_REQ;
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      wb_st_q <= WB_IDLE;
      wb_ring_q <= 1'b0;
      wb_cnt_q <= 17'h0;
      O_WB_RING <= 1'b0;
      O_WB_ADDR <= 64'h0;
      O_WB_CNT <= 17'h0;
    end else if (I_CE) begin
      unique case (wb_st_q)
        WB_IDLE: begin
          if (|want) begin
            wb_st_q <= WB_REQ;
            wb_ring_q <= ~want[0];
            wb_cnt_q <= want[0] ? cnt_w[0] : cnt_w[1];
            O_WB_RING <= ~want[0];
            O_WB_CNT <= want[0] ? cnt_w[0] : cnt_w[1];
            O_WB_ADDR <= want[0] ?
              {bah_q[0], bal_q[0], 4'h0} + {44'h0, head_q[0], 4'h0} :
              {bah_q[1], bal_q[1], 4'h0} + {44'h0, head_q[1], 4'h0};
          end
        end
        WB_REQ: if (I_WB_ACK) wb_st_q <= WB_WAIT;
        WB_WAIT: if (I_WB_DONE) wb_st_q <= WB_IDLE;
        default: wb_st_q <= WB_IDLE;
      endcase
    end
  end

  // flush request; timer causes wait for it so memory is current first
  assign rxt_flushed = tmr_pend_q && !flush_q;
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      flush_q <= 1'b0;
      tmr_pend_q <= 1'b0;
    end else if (I_CE) begin
      if ((wr && I_PADDR == OFF_PDT && I_PWDATA[FPD_BIT]) || tmr_exp) begin
        flush_q <= 1'b1; // see [RL5]
      end else if (pend_q[0] == 17'h0 && pend_q[1] == 17'h0 && wb_st_q == WB_IDLE) begin
        flush_q <= 1'b0;
      end
      if (tmr_exp) begin
        tmr_pend_q <= 1'b1;
      end else if (rxt_flushed) begin
        tmr_pend_q <= 1'b0; // see [RL4]
      end
    end
  end

  // shared prescaler for all delay timers
  assign tick = tick_q == 16'(TICK - 1);
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      tick_q <= 16'h0;
    end else if (I_CE) begin
      tick_q <= tick ? 16'h0 : tick_q + 16'h1;
    end
  end

  // packet and absolute delay timers
  assign small_evt = I_PKT_DONE && I_CE && srpd_q[15:0] != 16'h0
                     && I_PKT_LEN < srpd_q[15:0]; // see [RL20]
  assign ovr_evt = I_FIFO_WR && I_FIFO_FULL && I_CE;
  assign O_FIFO_DROP = ovr_evt; // see [RL22]
  assign tmr_exp = I_CE && ((tick && pdt_act_q && pdt_cnt_q == 16'h1)
                   || (tick && adt_act_q && adt_cnt_q == 16'h1)
                   || (I_PKT_DONE && pdt_q[15:0] == 16'h0)); // see [RL17]
  assign intr_any = tmr_exp || small_evt || ovr_evt || |mt_hit;
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      pdt_act_q <= 1'b0;
      adt_act_q <= 1'b0;
      pdt_cnt_q <= 16'h0;
      adt_cnt_q <= 16'h0;
    end else if (I_CE) begin
      if (intr_any) begin
        // every receive interrupt except the ack cause parks both timers until the next packet
        pdt_act_q <= 1'b0; // see [RL19]
        adt_act_q <= 1'b0;
      end else begin
        if (I_PKT_DONE) begin
          pdt_act_q <= 1'b1;
          pdt_cnt_q <= pdt_q[15:0]; // see [RL16]
        end else if (tick && pdt_act_q) begin
          pdt_cnt_q <= pdt_cnt_q - 16'h1;
        end
        if (I_PKT_DONE && !adt_act_q && adt_q[15:0] != 16'h0) begin
          adt_act_q <= 1'b1; // see [RL18]
          adt_cnt_q <= adt_q[15:0];
        end else if (tick && adt_act_q) begin
          adt_cnt_q <= adt_cnt_q - 16'h1;
        end
      end
    end
  end

  // ack frame delay; only counts in split or extended status formats
  assign ack_en = ctrl_q[DTYP_LSB +: 2] == DTYP_PSPLIT || ctrl_q[EXST_BIT]; // see [RL21]
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ack_act_q <= 1'b0;
      ack_cnt_q <= 16'h0;
    end else if (I_CE) begin
      if (I_PKT_DONE && I_PKT_ACK && ack_en && !ack_act_q) begin
        ack_act_q <= 1'b1;
        ack_cnt_q <= ackd_q[15:0];
      end else if (ack_act_q && (ack_cnt_q == 16'h0 || (tick && ack_cnt_q == 16'h1))) begin
        ack_act_q <= 1'b0;
      end else if (ack_act_q && tick) begin
        ack_cnt_q <= ack_cnt_q - 16'h1;
      end
    end
  end

  // cause events; a set in the clearing cycle survives the clear
  always_comb begin
    cause_set = '0;
    cause_set[C_RXT] = rxt_flushed || small_evt;
    cause_set[C_SRPD] = small_evt;
    cause_set[C_MINTH] = |mt_hit;
    cause_set[C_OVR] = ovr_evt;
    cause_set[C_ACK] = I_CE && ack_act_q &&
                       (ack_cnt_q == 16'h0 || (tick && ack_cnt_q == 16'h1));
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      icr_q <= '0;
    end else if (I_CE) begin
      icr_q <= (icr_q & ~(wr_icr ? I_PWDATA[NCAUSE-1:0] : '0)) | cause_set; // see [RL23]
    end
  end

  // level request, gated by the mask
  assign O_IRQ = |(icr_q & ims_q[NCAUSE-1:0]); // see [RL23]

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);

  sequence s_wb_go;
    O_WB_REQ ##1 !O_WB_REQ;
  endsequence
  AST_WB_CHUNK: assert property (O_WB_REQ |-> // see [RL9]
    O_WB_CNT != 17'h0 && O_WB_CNT <= pend_q[O_WB_RING])
    else $error("write-back chunk count out of range");
  AST_WB_GAP: assert property (s_wb_go |=> !O_WB_REQ) // see [RL9]
    else $error("write-back requested with no idle cycle");
  AST_WB_HOLD: assert property (O_WB_REQ && !(I_WB_ACK && I_CE) |=> // see [RL1]
    O_WB_REQ && $stable(O_WB_ADDR))
    else $error("write-back request dropped before accept");
  AST_WTH: assert property (wb_st_q == WB_IDLE && I_CE && ctrl_q[5:0] != 6'h0 && // see [RL2]
    pend_q[0] >= {11'h0, ctrl_q[5:0]} |=> O_WB_REQ && !O_WB_RING)
    else $error("threshold did not start a write-back");
  AST_RXT_AFTER_FLUSH: assert property ($rose(icr_q[C_RXT]) && !$past(small_evt) |-> // see [RL4]
    $past(pend_q[0]) == 17'h0 && $past(pend_q[1]) == 17'h0)
    else $error("timer cause raised with descriptors unwritten");
  AST_SMALL: assert property (small_evt |=> icr_q[C_SRPD] && icr_q[C_RXT]) // see [RL20]
    else $error("small packet causes not set");
  AST_TIMERS_IDLE: assert property (intr_any |=> !pdt_act_q && !adt_act_q) // see [RL19]
    else $error("timer left running after interrupt");
  AST_ADT_NORELOAD: assert property (adt_act_q && I_PKT_DONE && I_CE && // see [RL18]
    !intr_any && !tick |=> adt_cnt_q == $past(adt_cnt_q))
    else $error("absolute timer reloaded by later packet");
  AST_OVR_STICKY: assert property (ovr_evt ##1 // see [RL22]
    (!(wr_icr && I_PWDATA[C_OVR]))[*3] |-> icr_q[C_OVR])
    else $error("overrun cause lost");
  AST_FLUSH_DONE: assert property (wr && I_PADDR == OFF_PDT && // see [RL5]
    I_PWDATA[FPD_BIT] |=> flush_q)
    else $error("flush request not taken");
  AST_PDT_ZERO: assert property (I_PKT_DONE && I_CE && pdt_q[15:0] == 16'h0 |=> // see [RL17]
    tmr_pend_q || icr_q[C_RXT])
    else $error("zero delay did not signal the packet");
endmodule

/* File: verif/rxwb_host_model.sv */
// host memory model that takes descriptor write-back requests
module rxwb_host_model (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_req,
  input wire logic [63:0] i_addr,
  input wire logic [16:0] i_cnt,
  input wire logic i_slow,
  output logic o_ack,
  output logic o_done,
  output logic [63:0] o_last_addr,
  output logic [16:0] o_last_cnt,
  output int o_writes
);
  timeunit 1ns;
  timeprecision 1ps;

  // accept, write the handed descriptors, then report completion
  // slow mode stretches both the accept and the memory write
  initial begin
    o_ack = 1'b0;
    o_done = 1'b0;
    o_last_addr = 64'h0;
    o_last_cnt = 17'h0;
    o_writes = 0;
    forever begin
      @(posedge i_clk);
      if (i_reset_n && i_req) begin
        repeat (i_slow ? 3 : 0) @(posedge i_clk);
        o_ack <= 1'b1;
        o_last_addr <= i_addr;
        o_last_cnt <= i_cnt;
        @(posedge i_clk);
        o_ack <= 1'b0;
        repeat (i_slow ? 6 : 1) @(posedge i_clk);
        o_done <= 1'b1;
        o_writes <= o_writes + 1;
        @(posedge i_clk);
        o_done <= 1'b0;
      end
    end
  end
endmodule

/* File: verif/rxwb_top_tb_top.sv */
// self-checking bench for the descriptor write-back and interrupt block
`define CHK(g, e) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    n_fail++; \
    $display("[FAIL] %0t got %0h want %0h", $time, (g), (e)); \
  end \
end
module rxwb_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rxwb_pkg::*;
  localparam logic [63:0] B0 = 64'h0000_0001_1234_5670;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic pready, pslverr, err, store_en, fifo_drop, wb_req, wb_ring, wb_ack, wb_done, irq;
  logic desc_used = 1'b0, desc_ring = 1'b0, desc_null = 1'b0;
  logic pkt_done = 1'b0, pkt_ack = 1'b0, fifo_wr = 1'b0, fifo_full = 1'b0;
  logic [15:0] pkt_len = 16'h0;
  logic [7:0] null_status;
  logic [1:0] ring_empty;
  logic [63:0] wb_addr, host_addr;
  logic [16:0] wb_cnt, host_cnt;
  logic [31:0] ack_ctl [3] = '{32'h3f, 32'h13f, 32'h43f};
  logic ack_exp [3] = '{1'b0, 1'b1, 1'b1};
  int host_writes, w0;
  int n_fail = 0;
  int tests_run = 0;

  // short timer unit keeps the delay scenarios brief
  rxwb_top #(.TICK(2)) dut (.I_CLK(clk), .I_RESET_N(rst_n), .I_CE(1'b1),
    .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_DESC_USED(desc_used), .I_DESC_RING(desc_ring), .I_DESC_NULL(desc_null),
    .I_PKT_DONE(pkt_done), .I_PKT_LEN(pkt_len), .I_PKT_ACK(pkt_ack),
    .I_FIFO_WR(fifo_wr), .I_FIFO_FULL(fifo_full), .O_STORE_EN(store_en),
    .O_NULL_STATUS(null_status), .O_RING_EMPTY(ring_empty), .O_FIFO_DROP(fifo_drop),
    .O_WB_REQ(wb_req), .O_WB_RING(wb_ring), .O_WB_ADDR(wb_addr), .O_WB_CNT(wb_cnt),
    .I_WB_ACK(wb_ack), .I_WB_DONE(wb_done), .O_IRQ(irq));

  rxwb_host_model host (.i_clk(clk), .i_reset_n(rst_n), .i_req(wb_req),
    .i_addr(wb_addr), .i_cnt(wb_cnt), .i_slow(slow), .o_ack(wb_ack),
    .o_done(wb_done), .o_last_addr(host_addr), .o_last_cnt(host_cnt),
    .o_writes(host_writes));

  // 25 MHz core clock
  always #20 clk = ~clk;

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no fixed wait count: only the watchdog ends a stuck transfer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rdata, e)
  endtask

  function automatic logic [7:0] ra(input int r, input logic [4:0] o);
    return 8'h40 + 8'(r * 32) + {3'h0, o};
  endfunction

  // one used descriptor per two cycles
  task automatic use_desc(input logic r, input int n);
    repeat (n) begin
      desc_ring <= r;
      desc_used <= 1'b1;
      @(posedge clk);
      desc_used <= 1'b0;
      @(posedge clk);
    end
  endtask

  task automatic pkt(input logic [15:0] len, input logic ack);
    pkt_len <= len;
    pkt_ack <= ack;
    pkt_done <= 1'b1;
    @(posedge clk);
    pkt_done <= 1'b0;
    pkt_ack <= 1'b0;
    @(posedge clk);
  endtask

  // bounded wait for the next completed write-back, then its shape
  task automatic wb_chk(input logic [63:0] ea, input logic [16:0] ec);
    int n, w;
    n = 0;
    w = host_writes;
    while (host_writes == w && n < 100) begin
      @(posedge clk);
      n++;
    end
    `CHK(host_addr, ea)
    `CHK(host_cnt, ec)
    repeat (2) @(posedge clk);
  endtask

  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    `CHK(irq, 1'b1)
  endtask

  task automatic note(input string s);
    $display("test %s done", s);
  endtask

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // hang guard: the sequence needs about 2600 cycles
  initial begin
    repeat (10000) @(posedge clk);
    n_fail++;
    end_of_test();
  end

  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK(ring_empty, 2'b11)
    `CHK(irq, 1'b0)
    chk_rd(OFF_CTRL, 32'h0);
    apb(1'b0, 8'hfc, 32'h0);
    `CHK(err, 1'b1)
    wr(OFF_CTRL, 32'h3f);
    wr(ra(0, RO_BAL), 32'h1234567f);
    chk_rd(ra(0, RO_BAL), 32'h12345670);
    wr(ra(0, RO_BAH), 32'h1);
    wr(ra(0, RO_LEN), 32'h80);
    wr(ra(0, RO_TAIL), 32'h7);
    // three used stay pending, the fourth completes a line
    use_desc(1'b0, 3);
    repeat (6) @(posedge clk);
    `CHK(host_writes, 0)
    use_desc(1'b0, 1);
    wb_chk(B0, 17'h4);
    `CHK(wb_ring, 1'b0)
    chk_rd(ra(0, RO_HEAD), 32'h4);
    wr(OFF_CTRL, 32'h2);
    use_desc(1'b0, 2);
    wb_chk(B0 + 64'h40, 17'h2);
    note("packing");
    // ring end forces a write and head wraps; slow host meanwhile
    wr(OFF_CTRL, 32'h3f);
    wr(ra(0, RO_TAIL), 32'h2);
    slow <= 1'b1;
    use_desc(1'b0, 2);
    wb_chk(B0 + 64'h60, 17'h2);
    chk_rd(ra(0, RO_HEAD), 32'h0);
    use_desc(1'b0, 3);
    `CHK(ring_empty[0], 1'b1)
    wr(OFF_PDT, 32'h80000000);
    wb_chk(B0, 17'h2);
    chk_rd(ra(0, RO_HEAD), 32'h2);
    note("wrap and flush");
    // null buffer on the second ring
    wr(ra(1, RO_BAL), 32'h2000);
    wr(ra(1, RO_LEN), 32'h80);
    wr(ra(1, RO_TAIL), 32'h4);
    desc_null <= 1'b1;
    @(posedge clk);
    `CHK(store_en, 1'b0)
    use_desc(1'b1, 1);
    desc_null <= 1'b0;
    @(posedge clk);
    `CHK(null_status, DD_ONLY)
    `CHK(store_en, 1'b1)
    `CHK(ring_empty, 2'b01)
    note("null descriptor");
    // half of ring 0 went free on its third descriptor; clear before unmasking
    chk_rd(OFF_ICR, 32'h2);
    wr(OFF_ICR, 32'h1f);
    // packet delay timer reload, flush before the cause
    wr(OFF_IMS, 32'h1f);
    wr(OFF_PDT, 32'ha);
    w0 = host_writes;
    pkt(16'd100, 1'b0);
    repeat (14) @(posedge clk);
    pkt(16'd100, 1'b0);
    repeat (12) @(posedge clk);
    `CHK(irq, 1'b0)
    wait_irq(60);
    `CHK(host_writes == w0 + 1, 1'b1)
    `CHK(wb_ring, 1'b1)
    chk_rd(ra(1, RO_HEAD), 32'h1);
    repeat (5) @(posedge clk);
    chk_rd(OFF_ICR, 32'h1);
    `CHK(irq, 1'b1)
    wr(OFF_ICR, 32'h1f);
    chk_rd(OFF_ICR, 32'h0);
    `CHK(irq, 1'b0)
    wr(OFF_PDT, 32'h0);
    pkt(16'd100, 1'b0);
    wait_irq(20);
    wr(OFF_ICR, 32'h1f);
    note("packet timer");
    // absolute timer is not pushed out by later packets
    wr(OFF_PDT, 32'h3e8);
    wr(OFF_ADT, 32'ha);
    repeat (8) begin
      pkt(16'd100, 1'b0);
      repeat (4) @(posedge clk);
    end
    chk_rd(OFF_ICR, 32'h1);
    wr(OFF_ADT, 32'h0);
    repeat (60) @(posedge clk);
    wr(OFF_ICR, 32'h1f);
    note("absolute timer");
    // ack frames in each descriptor mode, ack cause masked
    wr(OFF_ACKD, 32'h3);
    wr(OFF_IMS, 32'h0f);
    for (int i = 0; i < 3; i++) begin
      wr(OFF_CTRL, ack_ctl[i]);
      pkt(16'd100, 1'b1);
      repeat (12) @(posedge clk);
      apb(1'b0, OFF_ICR, 32'h0);
      `CHK(rdata[C_ACK], ack_exp[i])
      `CHK(irq, 1'b0)
      wr(OFF_ICR, 32'h1f);
    end
    note("ack frames");
    // size equal to the threshold is not small, one below is
    wr(OFF_CTRL, 32'h3f);
    wr(OFF_SRPD, 32'h40);
    pkt(16'd64, 1'b0);
    repeat (8) @(posedge clk);
    chk_rd(OFF_ICR, 32'h0);
    pkt(16'd63, 1'b0);
    repeat (8) @(posedge clk);
    chk_rd(OFF_ICR, 32'h9);
    wr(OFF_ICR, 32'h1f);
    repeat (2100) @(posedge clk);
    chk_rd(OFF_ICR, 32'h0);
    note("small packet");
    // free count hits half the ring, then a fifo overrun
    wr(ra(1, RO_TAIL), 32'h6);
    use_desc(1'b1, 1);
    fifo_wr <= 1'b1;
    @(posedge clk);
    `CHK(fifo_drop, 1'b0)
    fifo_full <= 1'b1;
    @(posedge clk);
    `CHK(fifo_drop, 1'b1)
    fifo_wr <= 1'b0;
    fifo_full <= 1'b0;
    @(posedge clk);
    chk_rd(OFF_ICR, 32'h6);
    note("threshold and overrun");
    end_of_test();
  end
endmodule
